// ### src/bct_consts.vh
// Purpose: constants for the burst capture trigger sequencer
// Assumes: 100 MHz pclk, APB register access, 32-bit words
// Notes: all offsets are byte addresses of aligned 32-bit registers
`ifndef BCT_CONSTS_VH
`define BCT_CONSTS_VH

`define BCT_OFF_CTRL 32'h00
`define BCT_OFF_CONFIG 32'h04
`define BCT_OFF_INTERVAL 32'h08
`define BCT_OFF_SCANS 32'h0c
`define BCT_OFF_PRETRIG 32'h10
`define BCT_OFF_LIMIT 32'h14
`define BCT_OFF_EXCITE 32'h18
`define BCT_OFF_BASE 32'h1c
`define BCT_OFF_STATUS 32'h20
`define BCT_OFF_SLOT 32'h24

`define BCT_CTRL_START 0
`define BCT_CTRL_ABORT 1

`define BCT_CFG_REPS_HI 3
`define BCT_CFG_REPS_LO 0
`define BCT_CFG_RANGE_HI 7
`define BCT_CFG_RANGE_LO 4
`define BCT_CFG_FIRST_HI 11
`define BCT_CFG_FIRST_LO 8
`define BCT_CFG_TSRC_HI 13
`define BCT_CFG_TSRC_LO 12
`define BCT_CFG_TCOND_HI 18
`define BCT_CFG_TCOND_LO 16
`define BCT_CFG_DEST 20
`define BCT_CFG_IPOS_HI 31
`define BCT_CFG_IPOS_LO 24

`define BCT_TSRC_ANALOG 2'h0
`define BCT_TSRC_DIGITAL 2'h1
`define BCT_TSRC_ANALOG_PORT 2'h2

`define BCT_TCOND_NOW 3'h0
`define BCT_TCOND_ABOVE 3'h1
`define BCT_TCOND_BELOW 3'h2
`define BCT_TCOND_RISE 3'h3
`define BCT_TCOND_FALL 3'h4

`define BCT_CFG_RESET 32'h0000_f001
`define BCT_INTERVAL_RESET 32'h0000_03ca
`define BCT_SCANS_RESET 32'h0000_0001
`define BCT_EMPTY_SLOT 32'hfffe_7961
`define BCT_STREAM_MARK 8'hfc

`define BCT_CLK_MHZ 100
`define BCT_MEAS_MIN_US 32'd970
`define BCT_MEAS_MAX_US 32'd50000
`define BCT_INTEG_US 32'd250
`define BCT_MEAS_MIN_CYC (970 * `BCT_CLK_MHZ)

`endif

// ### src/bct_top.v
// Purpose: burst capture sequencer with trigger and pre-trigger history
// Assumes: converter front end answers conv_start with one conv_done pulse
// Notes: pre-trigger depth is bounded by HIST_DEPTH scans
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "bct_consts.vh"
module bct_top #(
  parameter MAX_CH = 4,
  parameter HIST_DEPTH = 16,
  parameter MEM_LOCS = 4096,
  parameter CYC_PER_US = `BCT_CLK_MHZ,
  parameter MEAS_MIN_CYC = `BCT_MEAS_MIN_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire single_ended_input_one_high_side,
  input wire conv_done,
  input wire [31:0] conv_mv,
  input wire [15:0] conv_raw,
  output reg conv_start,
  output reg [3:0] conv_channel,
  output reg [3:0] conv_range,
  output reg conv_fast,
  output reg [31:0] conv_integ_us,
  output reg excite_one_en,
  output reg [31:0] excite_one_mv,
  output reg ctrl_port_one,
  output reg mem_wr,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_data,
  output reg ser_valid,
  output reg [15:0] ser_word,
  input wire ser_ready,
  output reg busy
);
  localparam HW = (HIST_DEPTH > 1) ? $clog2(HIST_DEPTH) : 1;
  // One-hot sequencer: idle, serial header, wait for timers,
  // conversion in flight, pre-trigger copy-out, end-of-scan bookkeeping
  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_HDR = 6'b000010;
  localparam [5:0] S_WAIT = 6'b000100;
  localparam [5:0] S_CONV = 6'b001000;
  localparam [5:0] S_PRE = 6'b010000;
  localparam [5:0] S_END = 6'b100000;

  reg [31:0] cfg_reg, interval_reg, scans_reg, pretrig_reg, limit_reg, excite_reg, base_reg;
  reg [5:0] state_reg;
  reg [3:0] ch_reg;
  reg [31:0] slot_reg, scan_tmr_reg, meas_tmr_reg, pre_i_reg;
  reg [3:0] pre_ch_reg;
  reg [HW-1:0] wp_reg;
  reg [HW:0] hist_cnt_reg;
  reg trig_reg, trig_scan_reg, armed_reg, dig_smp_reg, abort_reg;
  reg done_reg, err60_reg, err61_reg, errcfg_reg, overrun_reg;
  reg dig_meta_reg, dig_sync_reg;
  // History holds HIST_DEPTH scans per channel, index is scan*MAX_CH+channel
  reg [31:0] hist_mem [0:HIST_DEPTH*MAX_CH-1];

  wire [3:0] reps = cfg_reg[`BCT_CFG_REPS_HI:`BCT_CFG_REPS_LO];
  wire [1:0] tsrc = cfg_reg[`BCT_CFG_TSRC_HI:`BCT_CFG_TSRC_LO];
  wire [2:0] tcond = cfg_reg[`BCT_CFG_TCOND_HI:`BCT_CFG_TCOND_LO];
  wire to_serial = cfg_reg[`BCT_CFG_DEST];
  wire [31:0] pre_eff = to_serial ? 32'h0 : pretrig_reg;

  // Bus handshake: one wait-free access phase; reads decoded on the setup edge, writes in the access phase
  wire acc = psel && penable && pready;
  wire wr_acc = acc && pwrite;
  wire start_req = wr_acc && (paddr == `BCT_OFF_CTRL) && pwdata[`BCT_CTRL_START];
  wire abort_req = wr_acc && (paddr == `BCT_OFF_CTRL) && pwdata[`BCT_CTRL_ABORT];
  wire cfg_wr = wr_acc && !busy;
  wire mapped = (paddr[31:6] == 26'h0) && (paddr[1:0] == 2'h0) && (paddr[5:2] <= 4'h9);

  // Checks that the documented device ran at program compile time, done at start
  wire [35:0] need_prod = scans_reg * reps;
  wire [36:0] need_locs = {5'h00, base_reg} + {1'b0, need_prod};
  wire e60 = !to_serial && (need_locs > MEM_LOCS);
  wire [35:0] int_min = `BCT_MEAS_MIN_US * reps;
  wire [35:0] int_max = `BCT_MEAS_MAX_US * reps;
  wire e61 = ({4'h0, interval_reg} < int_min) || ({4'h0, interval_reg} > int_max);
  wire ecfg = (reps == 4'h0) || (reps > MAX_CH) || (tsrc > `BCT_TSRC_ANALOG_PORT) || (tcond > `BCT_TCOND_FALL) ||
              (!to_serial && ((scans_reg == 32'h0) || (pretrig_reg >= scans_reg) || (pretrig_reg > HIST_DEPTH)));

  // Scan timer spans a whole scan, measure timer one conversion slot
  wire [63:0] scan_cyc = interval_reg * CYC_PER_US;
  wire [31:0] scan_load = scan_cyc[31:0] - 32'd1;
  wire [31:0] meas_load = MEAS_MIN_CYC - 1;

  // Trigger evaluation on the first channel result of each scan
  wire analog = (tsrc != `BCT_TSRC_DIGITAL);
  wire above = analog ? ($signed(conv_mv) > $signed(limit_reg)) : dig_smp_reg;
  wire below = analog ? ($signed(conv_mv) < $signed(limit_reg)) : !dig_smp_reg;
  reg hit;
  always @* begin
    case (tcond)
      `BCT_TCOND_ABOVE: hit = above;
      `BCT_TCOND_BELOW: hit = below;
      `BCT_TCOND_RISE: hit = armed_reg && above;
      `BCT_TCOND_FALL: hit = armed_reg && below;
      default: hit = 1'b0;
    endcase
  end
  wire eval_now = (ch_reg == 4'h0) && !trig_reg && conv_done;
  wire hit_now = eval_now && hit;
  wire trig_now = trig_reg || hit_now;
  wire [31:0] slot_now = hit_now ? pre_eff : slot_reg;
  wire last_ch = (ch_reg == reps - 4'h1);

  wire [35:0] ch_off = ch_reg * scans_reg;
  wire [31:0] cur_addr = base_reg + ch_off[31:0] + slot_now;
  wire [35:0] pre_off = pre_ch_reg * scans_reg;
  wire [31:0] pre_addr = base_reg + pre_off[31:0] + pre_i_reg;
  // Pre-trigger source scan counts back from the write pointer, wrapping
  wire [31:0] pre_k = pretrig_reg - pre_i_reg;
  wire [31:0] wp_ext = {{(32-HW){1'b0}}, wp_reg};
  wire [31:0] src_scan = (wp_ext >= pre_k) ? (wp_ext - pre_k) : (wp_ext + HIST_DEPTH - pre_k);
  wire [31:0] src_idx = src_scan * MAX_CH + {28'h0, pre_ch_reg};
  wire [31:0] cur_idx = wp_ext * MAX_CH + {28'h0, ch_reg};
  wire pre_avail = (pre_k <= {{(31-HW){1'b0}}, hist_cnt_reg});

  // Trigger pin is asynchronous, two flops before the scan-start sample
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_meta_reg <= 1'b0;
      dig_sync_reg <= 1'b0;
    end else begin
      dig_meta_reg <= single_ended_input_one_high_side;
      dig_sync_reg <= dig_meta_reg;
    end
  end

  // History memory: plain flops, no reset needed for stored samples
  always @(posedge pclk) begin
    if ((state_reg == S_CONV) && conv_done && !to_serial)
      hist_mem[cur_idx[$clog2(HIST_DEPTH*MAX_CH)-1:0]] <= conv_mv;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cfg_reg <= `BCT_CFG_RESET;
      interval_reg <= `BCT_INTERVAL_RESET;
      scans_reg <= `BCT_SCANS_RESET;
      pretrig_reg <= 32'h0;
      limit_reg <= 32'h0;
      excite_reg <= 32'h0;
      base_reg <= 32'h0;
    end else begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !mapped;
      if (psel && !penable && !pready) begin
        case (paddr)
          `BCT_OFF_CONFIG: prdata <= cfg_reg;
          `BCT_OFF_INTERVAL: prdata <= interval_reg;
          `BCT_OFF_SCANS: prdata <= scans_reg;
          `BCT_OFF_PRETRIG: prdata <= pretrig_reg;
          `BCT_OFF_LIMIT: prdata <= limit_reg;
          `BCT_OFF_EXCITE: prdata <= excite_reg;
          `BCT_OFF_BASE: prdata <= base_reg;
          `BCT_OFF_STATUS: prdata <= {25'h0, overrun_reg, errcfg_reg, err61_reg, err60_reg, done_reg, trig_reg, busy};
          `BCT_OFF_SLOT: prdata <= slot_reg;
          default: prdata <= 32'h0;
        endcase
      end
      // Configuration is frozen while a burst runs so the address math stays stable
      if (cfg_wr) begin
        case (paddr)
          `BCT_OFF_CONFIG: cfg_reg <= pwdata;
          `BCT_OFF_INTERVAL: interval_reg <= pwdata;
          `BCT_OFF_SCANS: scans_reg <= pwdata;
          `BCT_OFF_PRETRIG: pretrig_reg <= pwdata;
          `BCT_OFF_LIMIT: limit_reg <= pwdata;
          `BCT_OFF_EXCITE: excite_reg <= pwdata;
          `BCT_OFF_BASE: base_reg <= pwdata;
          default: ;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      ch_reg <= 4'h0;
      slot_reg <= 32'h0;
      scan_tmr_reg <= 32'h0;
      meas_tmr_reg <= 32'h0;
      pre_i_reg <= 32'h0;
      pre_ch_reg <= 4'h0;
      wp_reg <= {HW{1'b0}};
      hist_cnt_reg <= {(HW+1){1'b0}};
      trig_reg <= 1'b0;
      trig_scan_reg <= 1'b0;
      armed_reg <= 1'b0;
      dig_smp_reg <= 1'b0;
      abort_reg <= 1'b0;
      done_reg <= 1'b0;
      err60_reg <= 1'b0;
      err61_reg <= 1'b0;
      errcfg_reg <= 1'b0;
      overrun_reg <= 1'b0;
      busy <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 4'h0;
      conv_range <= 4'h0;
      conv_fast <= 1'b0;
      conv_integ_us <= 32'h0;
      excite_one_en <= 1'b0;
      excite_one_mv <= 32'h0;
      ctrl_port_one <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 32'h0;
      mem_data <= 32'h0;
      ser_valid <= 1'b0;
      ser_word <= 16'h0;
    end else begin
      conv_start <= 1'b0;
      mem_wr <= 1'b0;
      if (ser_valid && ser_ready)
        ser_valid <= 1'b0;
      if (scan_tmr_reg != 32'h0)
        scan_tmr_reg <= scan_tmr_reg - 32'd1;
      if (meas_tmr_reg != 32'h0)
        meas_tmr_reg <= meas_tmr_reg - 32'd1;
      if (abort_req && busy)
        abort_reg <= 1'b1;
      case (state_reg)
        S_IDLE: begin
          // Start checks come first, any error leaves the sequencer idle
          if (start_req) begin
            done_reg <= 1'b0;
            err60_reg <= e60;
            err61_reg <= e61;
            errcfg_reg <= ecfg;
            if (!e60 && !e61 && !ecfg) begin
              busy <= 1'b1;
              overrun_reg <= 1'b0;
              abort_reg <= 1'b0;
              ch_reg <= 4'h0;
              wp_reg <= {HW{1'b0}};
              hist_cnt_reg <= {(HW+1){1'b0}};
              armed_reg <= 1'b0;
              trig_reg <= (tcond == `BCT_TCOND_NOW);
              trig_scan_reg <= (tcond == `BCT_TCOND_NOW);
              slot_reg <= pre_eff;
              ctrl_port_one <= (tcond == `BCT_TCOND_NOW) && (tsrc == `BCT_TSRC_ANALOG_PORT);
              conv_range <= cfg_reg[`BCT_CFG_RANGE_HI:`BCT_CFG_RANGE_LO];
              conv_fast <= 1'b1;
              conv_integ_us <= `BCT_INTEG_US;
              excite_one_en <= (excite_reg != 32'h0);
              excite_one_mv <= excite_reg;
              scan_tmr_reg <= 32'h0;
              meas_tmr_reg <= 32'h0;
              if (to_serial) begin
                ser_valid <= 1'b1;
                ser_word <= {`BCT_STREAM_MARK, cfg_reg[`BCT_CFG_IPOS_HI:`BCT_CFG_IPOS_LO]};
                state_reg <= S_HDR;
              end else begin
                state_reg <= S_WAIT;
              end
            end
          end
        end
        S_HDR: begin
          if (ser_ready)
            state_reg <= S_WAIT;
        end
        S_WAIT: begin
          // Abort is taken between conversions, the burst then closes as a normal end
          if (abort_reg) begin
            state_reg <= S_END;
          end else if ((meas_tmr_reg == 32'h0) && ((ch_reg != 4'h0) || (scan_tmr_reg == 32'h0))) begin
            if (ch_reg == 4'h0) begin
              dig_smp_reg <= dig_sync_reg;
              scan_tmr_reg <= scan_load;
            end
            meas_tmr_reg <= meas_load;
            conv_start <= 1'b1;
            conv_channel <= cfg_reg[`BCT_CFG_FIRST_HI:`BCT_CFG_FIRST_LO] + ch_reg;
            state_reg <= S_CONV;
          end
        end
        S_CONV: begin
          if (conv_done) begin
            if (eval_now) begin
              if (tcond == `BCT_TCOND_RISE)
                armed_reg <= armed_reg || below;
              if (tcond == `BCT_TCOND_FALL)
                armed_reg <= armed_reg || above;
            end
            if (hit_now) begin
              trig_reg <= 1'b1;
              trig_scan_reg <= 1'b1;
              slot_reg <= pre_eff;
              if (tsrc == `BCT_TSRC_ANALOG_PORT)
                ctrl_port_one <= 1'b1;
            end
            if (trig_now) begin
              if (to_serial) begin
                // Raw stream has no buffer; a stalled receiver loses the older word
                if (ser_valid && !ser_ready)
                  overrun_reg <= 1'b1;
                ser_valid <= 1'b1;
                ser_word <= conv_raw;
              end else begin
                mem_wr <= 1'b1;
                mem_addr <= cur_addr;
                mem_data <= conv_mv;
              end
            end
            if (last_ch) begin
              ch_reg <= 4'h0;
              if ((trig_scan_reg || hit_now) && !to_serial && (pretrig_reg != 32'h0)) begin
                pre_i_reg <= 32'h0;
                pre_ch_reg <= 4'h0;
                state_reg <= S_PRE;
              end else begin
                state_reg <= S_END;
              end
            end else begin
              ch_reg <= ch_reg + 4'h1;
              state_reg <= S_WAIT;
            end
          end
        end
        // Copy-out runs after the trigger scan, one location per clock;
        // slots with no history yet get the empty marker
        S_PRE: begin
          mem_wr <= 1'b1;
          mem_addr <= pre_addr;
          mem_data <= pre_avail ? hist_mem[src_idx[$clog2(HIST_DEPTH*MAX_CH)-1:0]] : `BCT_EMPTY_SLOT;
          if (pre_ch_reg == reps - 4'h1) begin
            pre_ch_reg <= 4'h0;
            pre_i_reg <= pre_i_reg + 32'd1;
            if (pre_i_reg == pretrig_reg - 32'd1)
              state_reg <= S_END;
          end else begin
            pre_ch_reg <= pre_ch_reg + 4'h1;
          end
        end
        // Once per scan: advance history pointer, count slots, decide whether done
        S_END: begin
          trig_scan_reg <= 1'b0;
          wp_reg <= (wp_ext == HIST_DEPTH - 1) ? {HW{1'b0}} : wp_reg + {{(HW-1){1'b0}}, 1'b1};
          if (!trig_reg && (hist_cnt_reg != HIST_DEPTH))
            hist_cnt_reg <= hist_cnt_reg + {{HW{1'b0}}, 1'b1};
          if (trig_reg)
            slot_reg <= slot_reg + 32'd1;
          if (abort_reg || (trig_reg && (scans_reg != 32'h0) && (slot_reg + 32'd1 == scans_reg))) begin
            busy <= 1'b0;
            done_reg <= 1'b1;
            abort_reg <= 1'b0;
            ctrl_port_one <= 1'b0;
            excite_one_en <= 1'b0;
            excite_one_mv <= 32'h0;
            conv_fast <= 1'b0;
            state_reg <= S_IDLE;
          end else begin
            state_reg <= S_WAIT;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// ### verification/bct_checker.sv
// Purpose: port-level assertions for the burst sequencer
// Assumes: one pclk domain, zero-wait APB slave
// Notes: watches design outputs against their causes
`timescale 1ns/1ps
module bct_checker #(
  parameter MEAS_MIN_CYC = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire conv_start,
  input wire conv_fast,
  input wire [31:0] conv_integ_us,
  input wire excite_one_en,
  input wire [31:0] excite_one_mv,
  input wire ctrl_port_one,
  input wire mem_wr,
  input wire ser_valid,
  input wire ser_ready,
  input wire busy
);
  int gap;
  // Saturates so a long idle spell cannot wrap into a false short gap
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= 1000;
    else if (conv_start) gap <= 1;
    else if (gap < 1000) gap <= gap + 1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  property p_apb_ready; s_setup |=> s_access; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_apb_err; psel && penable && pready && paddr > 32'h24 |-> pslverr; endproperty
  a_apb_err: assert property (p_apb_err) else $error("unmapped access not flagged");
  property p_integ; conv_start |-> conv_fast && conv_integ_us == 32'd250; endproperty
  a_integ: assert property (p_integ) else $error("slow integration used");
  property p_single; conv_start |=> !conv_start; endproperty
  a_single: assert property (p_single) else $error("repeated conversion request");
  property p_spacing; conv_start |-> gap >= MEAS_MIN_CYC; endproperty
  a_spacing: assert property (p_spacing) else $error("conversions too close");
  property p_excite; conv_start |-> excite_one_en == (excite_one_mv != 32'h0); endproperty
  a_excite: assert property (p_excite) else $error("excitation state wrong");
  property p_busy; conv_start || mem_wr |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("activity outside a burst");
  property p_port; !busy |-> !ctrl_port_one; endproperty
  a_port: assert property (p_port) else $error("control port high when idle");
  property p_ser; ser_valid && !ser_ready |=> ser_valid; endproperty
  a_ser: assert property (p_ser) else $error("serial word dropped");
endmodule

// ### verification/bct_sensor_model.sv
// Purpose: converter front end answering each request with a ramp value
// Assumes: value = start + step * conversion count
// Notes: data lines show the inverted last value outside done
`timescale 1ns/1ps
module bct_sensor_model #(
  parameter LAT = 3
) (
  input wire pclk,
  input wire presetn,
  input wire conv_start,
  input wire seq_clear,
  input wire [31:0] mv_start,
  input wire [31:0] mv_step,
  output logic conv_done,
  output logic [31:0] conv_mv,
  output logic [15:0] conv_raw
);
  int cnt;
  int wait_c;
  logic [31:0] val;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      wait_c <= 0;
      val <= 32'h0;
      conv_done <= 1'b0;
      conv_mv <= 32'h0;
      conv_raw <= 16'h0;
    end else begin
      conv_done <= 1'b0;
      conv_mv <= ~val;
      conv_raw <= ~val[15:0];
      if (seq_clear) cnt <= 0;
      if (conv_start) wait_c <= LAT;
      else if (wait_c == 1) begin
        val <= mv_start + mv_step * cnt;
        conv_mv <= mv_start + mv_step * cnt;
        conv_raw <= 16'(mv_start + mv_step * cnt);
        conv_done <= 1'b1;
        cnt <= cnt + 1;
        wait_c <= 0;
      end else if (wait_c > 1) wait_c <= wait_c - 1;
    end
  end
endmodule

// ### verification/bct_top_bench.sv
// Purpose: self-checking bench for the burst sequencer
// Assumes: CYC_PER_US 1 and MEAS_MIN_CYC 4 to shorten scans
// Notes: one channel, ramp inputs give known trigger scans
`timescale 1ns/1ps
`include "bct_consts.vh"
module bct_top_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin = 0, ser_ready = 0, seq_clear = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, mem_addr, mem_data, conv_mv, conv_integ_us, excite_one_mv, rd;
  logic [31:0] mv_start = 0, mv_step = 0;
  logic [15:0] conv_raw, ser_word;
  logic [3:0] conv_channel, conv_range;
  logic pready, pslverr, conv_done, conv_start, conv_fast, excite_one_en, ctrl_port_one, mem_wr, ser_valid, busy;
  logic err, ctrl_hi;
  logic [31:0] mem [logic [31:0]];
  logic [15:0] ser_q [$];
  int fail_count = 0, n_checks = 0, cycles = 0;
  always #5 pclk = ~pclk;
  bct_top #(.CYC_PER_US(1), .MEAS_MIN_CYC(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .single_ended_input_one_high_side(pin), .conv_done, .conv_mv,
    .conv_raw, .conv_start, .conv_channel, .conv_range, .conv_fast, .conv_integ_us, .excite_one_en,
    .excite_one_mv, .ctrl_port_one, .mem_wr, .mem_addr, .mem_data, .ser_valid, .ser_word, .ser_ready, .busy);
  bct_sensor_model i_model (.pclk, .presetn, .conv_start, .seq_clear, .mv_start, .mv_step, .conv_done,
    .conv_mv, .conv_raw);
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (mem_wr === 1'b1) mem[mem_addr] = mem_data;
    if (ctrl_port_one === 1'b1) ctrl_hi = 1;
    if (ser_valid === 1'b1 && ser_ready === 1'b1) ser_q.push_back(ser_word);
    if (cycles == 90000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until pready is sampled high at a rising edge
  task automatic apb(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic setup(logic [31:0] cfg, logic [31:0] scans, logic [31:0] npre, logic [31:0] limit);
    apb(1, `BCT_OFF_CONFIG, cfg);
    apb(1, `BCT_OFF_SCANS, scans);
    apb(1, `BCT_OFF_PRETRIG, npre);
    apb(1, `BCT_OFF_LIMIT, limit);
    apb(1, `BCT_OFF_EXCITE, 32'h9c4);
    apb(1, `BCT_OFF_BASE, 32'h100);
    apb(1, `BCT_OFF_INTERVAL, 32'h3ca);
  endtask
  task automatic burst(logic [1:0] src, logic [2:0] cond, int npre, int scans, int trig, int limit, int st, int sp);
    int k;
    mv_start <= st;
    mv_step <= sp;
    seq_clear <= 1;
    ctrl_hi = 0;
    mem.delete();
    setup({12'h0, 1'b0, cond, 2'b0, src, 12'h0d1}, scans, npre, limit);
    seq_clear <= 0;
    apb(1, `BCT_OFF_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    chk("busy", busy, 32'h1);
    chk("range", conv_range, 32'hd);
    chk("excite", excite_one_mv, 32'h9c4);
    wait (busy === 1'b0);
    apb(0, `BCT_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h6);
    chk("writes", mem.num(), scans);
    for (int s = 0; s < scans; s++) begin
      k = trig - npre + s;
      chk("slot", mem[32'h100 + s], k < 0 ? `BCT_EMPTY_SLOT : st + sp * k);
    end
  endtask
  task automatic t_regs;
    apb(0, `BCT_OFF_CONFIG, 32'h0);
    chk("config", rd, `BCT_CFG_RESET);
    apb(0, `BCT_OFF_INTERVAL, 32'h0);
    chk("interval", rd, `BCT_INTERVAL_RESET);
    apb(1, `BCT_OFF_STATUS, 32'hff);
    apb(0, `BCT_OFF_STATUS, 32'h0);
    chk("status ro", rd, 32'h0);
    apb(0, 32'h28, 32'h0);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
  endtask
  task automatic t_errors;
    setup({20'h0, 12'h0d1}, 32'd4000, 32'h0, 32'h0);
    apb(1, `BCT_OFF_CTRL, 32'h1);
    apb(0, `BCT_OFF_STATUS, 32'h0);
    chk("err60", {rd[3], busy}, 32'h2);
    apb(1, `BCT_OFF_SCANS, 32'h2);
    apb(1, `BCT_OFF_INTERVAL, 32'h64);
    apb(1, `BCT_OFF_CTRL, 32'h1);
    apb(0, `BCT_OFF_STATUS, 32'h0);
    chk("err61", {rd[4], busy}, 32'h2);
  endtask
  task automatic t_serial;
    mv_start <= 7;
    mv_step <= 0;
    ser_q.delete();
    setup({8'h2a, 3'h0, 1'b1, 20'h002d1}, 32'h1, 32'h0, 32'h0);
    apb(1, `BCT_OFF_CTRL, 32'h1);
    wait (ser_valid === 1'b1);
    repeat (3) @(posedge pclk);
    chk("header", ser_word, {`BCT_STREAM_MARK, 8'h2a});
    ser_ready <= 1;
    wait (busy === 1'b0);
    repeat (4) @(posedge pclk);
    chk("words", ser_q.size(), 32'h2);
    chk("raw", ser_q[1], 32'h7);
    chk("channel", conv_channel, 32'h2);
    ser_ready <= 0;
  endtask
  // Input already above the limit must fall first, so a rising ramp never triggers
  task automatic t_edge_hold;
    mv_start <= 20;
    mv_step <= 10;
    seq_clear <= 1;
    mem.delete();
    setup({12'h0, 1'b0, `BCT_TCOND_RISE, 2'b0, `BCT_TSRC_ANALOG, 12'h0d1}, 32'h2, 32'h0, 32'hf);
    seq_clear <= 0;
    apb(1, `BCT_OFF_CTRL, 32'h1);
    repeat (3000) @(posedge pclk);
    apb(0, `BCT_OFF_STATUS, 32'h0);
    chk("edge hold", rd, 32'h1);
    apb(1, `BCT_OFF_CTRL, 32'h2);
    wait (busy === 1'b0);
    chk("edge writes", mem.num(), 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_errors();
    burst(0, 0, 0, 3, 0, 15, 5, 10);
    burst(2, 1, 3, 5, 2, 15, 0, 10);
    chk("port high", ctrl_hi, 32'h1);
    chk("port low", ctrl_port_one, 32'h0);
    burst(0, 2, 1, 3, 2, 15, 30, -10);
    burst(0, 3, 1, 2, 2, 15, 0, 10);
    burst(0, 4, 0, 2, 2, 15, 30, -10);
    pin <= 1;
    burst(1, 1, 0, 2, 0, 15, 40, 10);
    pin <= 0;
    t_edge_hold();
    t_serial();
    summarize();
  end
endmodule
bind bct_top bct_checker #(.MEAS_MIN_CYC(MEAS_MIN_CYC)) i_chk (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .conv_start, .conv_fast, .conv_integ_us, .excite_one_en, .excite_one_mv,
  .ctrl_port_one, .mem_wr, .ser_valid, .ser_ready, .busy);
